// ===== src/ptwhc_buf_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ptwhc_buf_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic i_core_clk,
    input wire logic i_ce,
    input wire logic [AW-1:0] i_addr,
    input wire logic i_we_lo,
    input wire logic i_we_hi,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata
);
    logic [15:0] lo_mem [DEPTH];
    logic [15:0] hi_mem [DEPTH];
    logic [31:0] rdata_reg;

    // two halfword planes
    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (i_we_lo) begin
                lo_mem[i_addr] <= i_wdata[15:0];
            end
            if (i_we_hi) begin
                hi_mem[i_addr] <= i_wdata[31:16];
            end
            rdata_reg <= {hi_mem[i_addr], lo_mem[i_addr]};
        end
    end

    assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== src/ptwhc_pkg.sv
package ptwhc_pkg;
    // bus commands
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    // legal active-low byte enable patterns
    localparam logic [3:0] BE_DWORD = 4'h0;
    localparam logic [3:0] BE_LO_WORD = 4'hC;
    localparam logic [3:0] BE_HI_WORD = 4'h3;
    // window layout, byte offsets from the base
    localparam int WIN_BITS = 16;
    localparam logic [15:0] HWCTL_OFF = 16'h0000;
    localparam logic [15:0] SHARED_REGISTER_LO = 16'h0010;
    localparam logic [15:0] SHARED_REGISTER_HI = 16'h003B;
    localparam logic [15:0] BUFA_LO = 16'h0800;
    localparam logic [15:0] BUFG_HI = 16'h23FF;
    localparam logic [15:0] BUFH_LO = 16'h2400;
    localparam logic [15:0] BUFH_HI = 16'h27FF;
    // burst counter and burst buffer
    localparam int CNT_W = 8;
    localparam int BURST_DEPTH = 256;
    // configuration space byte offsets
    localparam logic [7:0] CFG_ID_OFF = 8'h00;
    localparam logic [7:0] CFG_CMD_OFF = 8'h04;
    localparam logic [7:0] CFG_REV_OFF = 8'h08;
    localparam logic [7:0] CFG_BAR0_OFF = 8'h10;
    localparam int CFG_MEM_EN_BIT = 1;
    localparam logic [15:0] CFG_CMD_RESET = 16'h0000;
    localparam logic [15:0] BAR0_RESET = 16'h0000;
    // hardware_control_reg fields
    localparam int HWC_LOCAL_RST_BIT = 0;
    localparam int HWC_FAIL_DRV_BIT = 1;
    localparam int HWC_FAIL_MON_BIT = 2;
    localparam int HWC_PWR_MON_BIT = 3;
    localparam int HWC_HOST_RST_BIT = 4;
    localparam logic HWC_CTL_RESET = 1'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DATA = 3'h1,
        ST_MEM = 3'h2,
        ST_EXT = 3'h3,
        ST_ACK = 3'h4,
        ST_ABT = 3'h5
    } ptwhc_state_t;

    typedef enum logic [1:0] {
        RG_UNUSED = 2'h0,
        RG_HWCTL = 2'h1,
        RG_EXT = 2'h2,
        RG_BURST = 2'h3
    } ptwhc_region_t;
endpackage

// ===== src/ptwhc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - claim config reads 1010 and writes 1011
// - target for memory read 0110 and write 0111 hits
// - read multiple 1100 and read line 1110 act as reads
// - decode a 64 Kbyte window based at BAR0
// - 32-bit ports, 16-bit granularity, no byte access to the window
// - unused window space ends in target abort
// - address phase loads the data phase address counter
// - counter advances after each phase with top byte enable low
// - 8-bit counter wraps 0xFF to 0x00
// - multi-phase access to non-burst region aborts
// - only single-clock memory may burst
// - only 0x2400 to 0x27FF accepts bursts
// - pure target; never starts a transaction
// - config offset 0x00 gives device id, 0x08 revision
// - shared register same from both sides
// - D00 zero asserts the local reset pin; reads back
// - D01 zero asserts the fail line; reads back
// - D00 and D01 clear after backplane reset or configuration
// - D02 shows live fail line level
// - D03 shows live power-fail line level
// - D04 is one while host bus is in reset
// - D05 to D31 read zero; software writes zero
module ptwhc_top
    import ptwhc_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h0ABC, // arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h01,
    parameter logic [23:0] CLASS_CODE = 24'h068000
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_addr_vld,
    input wire logic [31:0] i_addr,
    input wire logic [3:0] i_cmd,
    input wire logic i_cfg_sel,
    input wire logic i_data_vld,
    input wire logic [3:0] i_byte_enable_in,
    input wire logic [31:0] i_wdata,
    input wire logic i_txn_end,
    output logic o_claim,
    output logic o_data_ack,
    output logic o_target_abort,
    output logic [31:0] o_rd_data,
    output logic o_ext_req,
    output logic o_ext_we,
    output logic [15:0] o_ext_addr,
    output logic [3:0] o_ext_byte_enable,
    output logic [31:0] o_ext_wdata,
    input wire logic i_ext_ack,
    input wire logic [31:0] i_ext_rdata,
    input wire logic i_peer_wr,
    input wire logic [31:0] i_peer_wdata,
    output logic [31:0] o_hardware_control,
    input wire logic i_vme_rst_n,
    input wire logic i_fail_line,
    input wire logic i_power_fail,
    input wire logic i_host_rst_n,
    output logic o_local_reset_pin,
    output logic o_fail_line_o,
    output logic o_fail_line_oe
);
    function automatic ptwhc_region_t region_of(input logic [15:0] a);
        if (a == HWCTL_OFF) begin
            return RG_HWCTL;
        end else if (a >= SHARED_REGISTER_LO && a <= SHARED_REGISTER_HI) begin
            return RG_EXT;
        end else if (a >= BUFA_LO && a <= BUFG_HI) begin
            return RG_EXT;
        end else if (a >= BUFH_LO && a <= BUFH_HI) begin
            return RG_BURST;
        end
        return RG_UNUSED;
    endfunction

    function automatic logic be_legal(input logic [3:0] be);
        return be == BE_DWORD || be == BE_LO_WORD || be == BE_HI_WORD;
    endfunction

    ptwhc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [WIN_BITS-CNT_W-3:0] page_reg;
    logic cfg_txn_reg, wr_txn_reg, first_reg, claim_reg;
    logic [3:0] be_reg;
    logic [31:0] rd_reg;
    logic [15:0] cfg_cmd_reg, bar_hi_reg;
    logic local_rst_ctl_reg, fail_drv_reg;
    logic [3:0] sync1_reg, sync2_reg;
    logic ext_req_reg, ext_we_reg;
    logic [15:0] ext_addr_reg;
    logic [3:0] ext_be_reg;
    logic [31:0] ext_wdata_reg;

    // pins: vme reset, fail line, power fail, host reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end else if (i_ce) begin
            sync1_reg <= {i_host_rst_n, i_power_fail, i_fail_line,
                          i_vme_rst_n};
            sync2_reg <= sync1_reg;
        end
    end

    wire vme_rst_sync = ~sync2_reg[0];
    wire fail_line_mon = sync2_reg[1];
    wire power_fail_mon = sync2_reg[2];
    wire host_rst_mon = ~sync2_reg[3];

    wire is_cfg_cmd = i_cmd == CMD_CFG_RD || i_cmd == CMD_CFG_WR;
    wire is_rd_cmd = i_cmd == CMD_MEM_RD || i_cmd == CMD_MEM_RD_MULT
                     || i_cmd == CMD_MEM_RD_LINE;
    wire is_mem_cmd = is_rd_cmd || i_cmd == CMD_MEM_WR;
    wire win_hit = i_addr[31:WIN_BITS] == bar_hi_reg
                   && cfg_cmd_reg[CFG_MEM_EN_BIT];
    wire cfg_hit = is_cfg_cmd && i_cfg_sel;
    wire mem_hit = is_mem_cmd && win_hit;
    wire addr_take = i_addr_vld && (cfg_hit || mem_hit);

    wire [15:0] cur_addr = {page_reg, cnt_reg, 2'b00};
    wire [7:0] cfg_off = {cnt_reg[5:0], 2'b00};
    ptwhc_region_t cur_region;
    assign cur_region = region_of(cur_addr);

    wire phase_req = state_reg == ST_DATA && i_data_vld;
    wire be_ok = be_legal(i_byte_enable_in);
    wire bad_burst = !first_reg && cur_region != RG_BURST;
    wire mem_abort = !cfg_txn_reg && (cur_region == RG_UNUSED
                     || !be_ok || bad_burst);
    wire mem_go = phase_req && !cfg_txn_reg && !mem_abort;
    wire cfg_go = phase_req && cfg_txn_reg;
    wire lo_we = wr_txn_reg && !i_byte_enable_in[0];
    wire hi_we = wr_txn_reg && !i_byte_enable_in[3];
    wire buf_go = mem_go && cur_region == RG_BURST;
    wire hwc_go = mem_go && cur_region == RG_HWCTL;
    wire ext_go = mem_go && cur_region == RG_EXT;
    wire hwc_wr = hwc_go && lo_we;
    wire cfg_wr = cfg_go && wr_txn_reg;

    wire [31:0] buf_rdata;
    ptwhc_buf_mem #(
        .DEPTH(BURST_DEPTH),
        .AW(CNT_W)
    ) u_buf (
        .i_core_clk(i_core_clk),
        .i_ce(i_ce),
        .i_addr(cnt_reg),
        .i_we_lo(buf_go && lo_we),
        .i_we_hi(buf_go && hi_we),
        .i_wdata(i_wdata),
        .o_rdata(buf_rdata)
    );

    logic [31:0] hwc_value;
    always_comb begin
        hwc_value = 32'h0000_0000;
        hwc_value[HWC_LOCAL_RST_BIT] = local_rst_ctl_reg;
        hwc_value[HWC_FAIL_DRV_BIT] = fail_drv_reg;
        hwc_value[HWC_FAIL_MON_BIT] = fail_line_mon;
        hwc_value[HWC_PWR_MON_BIT] = power_fail_mon;
        hwc_value[HWC_HOST_RST_BIT] = host_rst_mon;
    end

    logic [31:0] cfg_value;
    always_comb begin
        case (cfg_off)
            CFG_ID_OFF: cfg_value = {DEVICE_ID, VENDOR_ID};
            CFG_CMD_OFF: cfg_value = {16'h0000, cfg_cmd_reg};
            CFG_REV_OFF: cfg_value = {CLASS_CODE, REVISION_ID};
            CFG_BAR0_OFF: cfg_value = {bar_hi_reg, 16'h0000};
            default: cfg_value = 32'h0000_0000;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = ST_IDLE;
            ST_DATA: begin
                if (phase_req && mem_abort) begin
                    state_next = ST_ABT;
                end else if (buf_go) begin
                    state_next = ST_MEM;
                end else if (ext_go) begin
                    state_next = ST_EXT;
                end else if (hwc_go || cfg_go) begin
                    state_next = ST_ACK;
                end
            end
            ST_MEM: state_next = ST_ACK;
            ST_EXT: state_next = i_ext_ack ? ST_ACK : ST_EXT;
            ST_ACK: state_next = ST_DATA;
            ST_ABT: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (i_txn_end && state_reg != ST_EXT) begin
            state_next = ST_IDLE;
        end
        if (addr_take) begin
            state_next = ST_DATA;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // address counter and context
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
            page_reg <= '0;
            cfg_txn_reg <= 1'b0;
            wr_txn_reg <= 1'b0;
            first_reg <= 1'b0;
            be_reg <= 4'hF;
        end else if (i_ce) begin
            if (addr_take) begin
                cnt_reg <= i_addr[CNT_W+1:2];
                page_reg <= i_addr[WIN_BITS-1:CNT_W+2];
                cfg_txn_reg <= is_cfg_cmd;
                wr_txn_reg <= i_cmd == CMD_MEM_WR || i_cmd == CMD_CFG_WR;
                first_reg <= 1'b1;
            end else if (state_reg == ST_ACK) begin
                first_reg <= 1'b0;
                if (!be_reg[3]) begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
            if (phase_req) begin
                be_reg <= i_byte_enable_in;
            end
        end
    end

    // claim holds until end or abort
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            claim_reg <= 1'b0;
        end else if (i_ce) begin
            if (addr_take) begin
                claim_reg <= 1'b1;
            end else if (state_next == ST_IDLE) begin
                claim_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            if (cfg_go) begin
                rd_reg <= cfg_value;
            end else if (hwc_go) begin
                rd_reg <= hwc_value;
            end else if (state_reg == ST_MEM) begin
                rd_reg <= buf_rdata;
            end else if (state_reg == ST_EXT && i_ext_ack) begin
                rd_reg <= i_ext_rdata;
            end
        end
    end

    // config command word and upper base half
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cfg_cmd_reg <= CFG_CMD_RESET;
            bar_hi_reg <= BAR0_RESET;
        end else if (i_ce && cfg_wr) begin
            if (cfg_off == CFG_CMD_OFF) begin
                if (!i_byte_enable_in[0]) begin
                    cfg_cmd_reg[7:0] <= i_wdata[7:0];
                end
                if (!i_byte_enable_in[1]) begin
                    cfg_cmd_reg[15:8] <= i_wdata[15:8];
                end
            end
            if (cfg_off == CFG_BAR0_OFF) begin
                if (!i_byte_enable_in[2]) begin
                    bar_hi_reg[7:0] <= i_wdata[23:16];
                end
                if (!i_byte_enable_in[3]) begin
                    bar_hi_reg[15:8] <= i_wdata[31:24];
                end
            end
        end
    end

    // host bus beats peer on a clash
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            local_rst_ctl_reg <= HWC_CTL_RESET;
            fail_drv_reg <= HWC_CTL_RESET;
        end else if (i_ce) begin
            if (vme_rst_sync) begin
                local_rst_ctl_reg <= HWC_CTL_RESET;
                fail_drv_reg <= HWC_CTL_RESET;
            end else if (hwc_wr) begin
                local_rst_ctl_reg <= i_wdata[HWC_LOCAL_RST_BIT];
                fail_drv_reg <= i_wdata[HWC_FAIL_DRV_BIT];
            end else if (i_peer_wr) begin
                local_rst_ctl_reg <= i_peer_wdata[HWC_LOCAL_RST_BIT];
                fail_drv_reg <= i_peer_wdata[HWC_FAIL_DRV_BIT];
            end
        end
    end

    // slow areas sit outside; request holds until ack
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ext_req_reg <= 1'b0;
            ext_we_reg <= 1'b0;
            ext_addr_reg <= 16'h0000;
            ext_be_reg <= 4'hF;
            ext_wdata_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            if (ext_go) begin
                ext_req_reg <= 1'b1;
                ext_we_reg <= wr_txn_reg;
                ext_addr_reg <= cur_addr;
                ext_be_reg <= i_byte_enable_in;
                ext_wdata_reg <= i_wdata;
            end else if (i_ext_ack) begin
                ext_req_reg <= 1'b0;
            end
        end
    end

    // target only: no initiator ports
    assign o_claim = claim_reg;
    assign o_data_ack = state_reg == ST_ACK;
    assign o_target_abort = state_reg == ST_ABT;
    assign o_rd_data = rd_reg;
    assign o_ext_req = ext_req_reg;
    assign o_ext_we = ext_we_reg;
    assign o_ext_addr = ext_addr_reg;
    assign o_ext_byte_enable = ext_be_reg;
    assign o_ext_wdata = ext_wdata_reg;
    assign o_hardware_control = hwc_value;
    assign o_local_reset_pin = ~local_rst_ctl_reg;
    // open drain: pull low while the bit is zero
    assign o_fail_line_o = 1'b0;
    assign o_fail_line_oe = ~fail_drv_reg;
endmodule
`default_nettype wire

// ===== tb/ptwhc_host_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module ptwhc_host_bfm (
    input wire logic i_core_clk,
    input wire logic i_ack,
    input wire logic i_abort,
    output logic o_addr_vld,
    output logic [31:0] o_addr,
    output logic [3:0] o_cmd,
    output logic o_cfg_sel,
    output logic o_data_vld,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata,
    output logic o_txn_end
);
    initial begin
        o_addr_vld = 1'b0;
        o_addr = 32'h0;
        o_cmd = 4'h0;
        o_cfg_sel = 1'b0;
        o_data_vld = 1'b0;
        o_be = 4'hF;
        o_wdata = 32'h0;
        o_txn_end = 1'b0;
    end

    // released lines show the inverse
    task automatic start(input logic [3:0] cmd, input logic [31:0] a);
        @(negedge i_core_clk);
        o_addr_vld = 1'b1;
        o_cmd = cmd;
        o_addr = a;
        o_cfg_sel = (cmd[3:1] == 3'h5);
        @(negedge i_core_clk);
        o_addr_vld = 1'b0;
        o_addr = ~a;
        o_cfg_sel = 1'b0;
    endtask

    // callers keep a burst in one area
    task automatic phase(input logic [3:0] be, input logic [31:0] wd,
                         output logic ab);
        @(negedge i_core_clk);
        o_data_vld = 1'b1;
        o_be = be;
        o_wdata = wd;
        do @(negedge i_core_clk);
        while (i_ack !== 1'b1 && i_abort !== 1'b1);
        ab = i_abort;
        o_data_vld = 1'b0;
        o_be = ~be;
        o_wdata = ~wd;
    endtask

    task automatic finish();
        @(negedge i_core_clk);
        o_txn_end = 1'b1;
        @(negedge i_core_clk);
        o_txn_end = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/ptwhc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ptwhc_top_props (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_addr_vld,
    input wire logic [3:0] i_cmd,
    input wire logic i_cfg_sel,
    input wire logic i_ext_ack,
    input wire logic i_vme_rst_n,
    input wire logic i_fail_line,
    input wire logic i_power_fail,
    input wire logic i_host_rst_n,
    input wire logic o_data_ack,
    input wire logic o_target_abort,
    input wire logic o_claim,
    input wire logic o_ext_req,
    input wire logic [31:0] o_hardware_control,
    input wire logic o_local_reset_pin,
    input wire logic o_fail_line_o,
    input wire logic o_fail_line_oe
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_cfg_claim: assert property (
        i_addr_vld && i_cfg_sel && i_cmd[3:1] == 3'h5 |=> o_claim)
        else $error("config not claimed");
    a_ack_single: assert property (
        o_data_ack |=> !o_data_ack)
        else $error("ack too long");
    a_abort_pulse: assert property (
        o_target_abort |-> !o_data_ack ##1 !o_target_abort)
        else $error("bad abort");
    a_ext_done: assert property (
        o_ext_req && i_ext_ack |=> o_data_ack)
        else $error("ext ack lost");
    a_rst_pin: assert property (
        o_local_reset_pin == !o_hardware_control[0])
        else $error("reset pin wrong");
    a_fail_drive: assert property (
        !o_fail_line_o && o_fail_line_oe == !o_hardware_control[1])
        else $error("fail drive wrong");
    a_upper_zero: assert property (
        o_hardware_control[31:5] == 27'h0)
        else $error("upper bits set");
    a_vme_clear: assert property (
        !i_vme_rst_n [*4] |-> o_hardware_control[1:0] == 2'h0)
        else $error("bits not cleared");
    a_host_mon: assert property (
        !i_host_rst_n [*3] |-> o_hardware_control[4])
        else $error("host monitor wrong");
    a_fail_mon: assert property (
        $stable(i_fail_line) [*3] |-> o_hardware_control[2] == i_fail_line)
        else $error("fail monitor wrong");
    a_power_mon: assert property (
        $stable(i_power_fail) [*3] |-> o_hardware_control[3] == i_power_fail)
        else $error("power monitor wrong");

    c_abort: cover property (o_target_abort);
    c_ext: cover property (o_ext_req && i_ext_ack);
    c_cfg: cover property (i_addr_vld && i_cfg_sel);
endmodule

bind ptwhc_top ptwhc_top_props u_props (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr_vld(i_addr_vld),
    .i_cmd(i_cmd), .i_cfg_sel(i_cfg_sel), .i_ext_ack(i_ext_ack),
    .i_vme_rst_n(i_vme_rst_n), .i_fail_line(i_fail_line),
    .i_power_fail(i_power_fail), .i_host_rst_n(i_host_rst_n),
    .o_data_ack(o_data_ack), .o_target_abort(o_target_abort),
    .o_claim(o_claim), .o_ext_req(o_ext_req),
    .o_hardware_control(o_hardware_control),
    .o_local_reset_pin(o_local_reset_pin), .o_fail_line_o(o_fail_line_o),
    .o_fail_line_oe(o_fail_line_oe)
);
`default_nettype wire

// ===== tb/ptwhc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ptwhc_top_tb
    import ptwhc_pkg::*;
;
    localparam logic [15:0] DEV = 16'h0C0D; // arbitrary value
    localparam logic [15:0] VEN = 16'h5EED; // arbitrary value
    localparam logic [7:0] REV = 8'h02;
    localparam logic [23:0] CLS = 24'h0B4000;
    localparam logic [31:0] BAR = 32'h5A5A0000;
    localparam logic [31:0] HI = 32'hFFFF0000;
    localparam logic [31:0] LO = 32'h0000FFFF;
    typedef struct packed {
        logic ab;
        logic [31:0] m;
        logic [31:0] d;
    } ptwhc_exp_t;
    ptwhc_exp_t exp_q[$];
    ptwhc_exp_t e;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 98;
    logic i_core_clk = 1'b0;
    logic i_rst_n, i_ce, i_ext_ack, i_peer_wr, i_vme_rst_n, i_fail_line;
    logic i_power_fail, i_host_rst_n, fl, pf, ab;
    logic [31:0] i_ext_rdata, i_peer_wdata;
    logic [31:0] d[4];
    logic [3:0] rcmd[3] = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
    wire logic i_addr_vld, i_cfg_sel, i_data_vld, i_txn_end, o_claim;
    wire logic [31:0] i_addr, i_wdata, o_rd_data, o_hardware_control;
    wire logic [3:0] i_cmd, i_byte_enable_in;
    wire logic [15:0] o_ext_addr;
    wire logic o_data_ack, o_target_abort, o_ext_req;
    wire logic o_local_reset_pin, o_fail_line_o, o_fail_line_oe;

    always #5 i_core_clk = ~i_core_clk;

    ptwhc_top #(.VENDOR_ID(VEN), .DEVICE_ID(DEV), .REVISION_ID(REV),
        .CLASS_CODE(CLS)) i_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_addr_vld(i_addr_vld), .i_addr(i_addr), .i_cmd(i_cmd),
        .i_cfg_sel(i_cfg_sel), .i_data_vld(i_data_vld),
        .i_byte_enable_in(i_byte_enable_in), .i_wdata(i_wdata),
        .i_txn_end(i_txn_end), .o_claim(o_claim), .o_data_ack(o_data_ack),
        .o_target_abort(o_target_abort), .o_rd_data(o_rd_data),
        .o_ext_req(o_ext_req), .o_ext_we(), .o_ext_addr(o_ext_addr),
        .o_ext_byte_enable(), .o_ext_wdata(), .i_ext_ack(i_ext_ack),
        .i_ext_rdata(i_ext_rdata), .i_peer_wr(i_peer_wr),
        .i_peer_wdata(i_peer_wdata), .o_hardware_control(o_hardware_control),
        .i_vme_rst_n(i_vme_rst_n), .i_fail_line(i_fail_line),
        .i_power_fail(i_power_fail), .i_host_rst_n(i_host_rst_n),
        .o_local_reset_pin(o_local_reset_pin), .o_fail_line_o(o_fail_line_o),
        .o_fail_line_oe(o_fail_line_oe)
    );

    ptwhc_host_bfm u_host (
        .i_core_clk(i_core_clk), .i_ack(o_data_ack), .i_abort(o_target_abort),
        .o_addr_vld(i_addr_vld), .o_addr(i_addr), .o_cmd(i_cmd),
        .o_cfg_sel(i_cfg_sel), .o_data_vld(i_data_vld),
        .o_be(i_byte_enable_in), .o_wdata(i_wdata), .o_txn_end(i_txn_end)
    );

    task automatic chk_word(input string nm, input logic [31:0] x, g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic chk_flag(input string nm, input logic x, input logic g);
        chk_word(nm, {31'h0, x}, {31'h0, g});
    endtask

    task automatic op(input logic [3:0] be, input logic [31:0] wd,
                      input logic xab, input logic [31:0] m,
                      input logic [31:0] xd);
        exp_q.push_back({xab, m, xd});
        u_host.phase(be, wd, ab);
    endtask

    task automatic one(input logic [3:0] cmd, input logic [31:0] a,
                       input logic [3:0] be, input logic [31:0] wd,
                       input logic xab, input logic [31:0] m,
                       input logic [31:0] xd);
        u_host.start(cmd, a);
        op(be, wd, xab, m, xd);
        u_host.finish();
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic print_verdict();
        if (exp_q.size() != 0) begin
            n_mismatch++;
        end
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // matched in issue order; sampled mid-cycle
    always @(negedge i_core_clk) begin
        if (o_data_ack === 1'b1 || o_target_abort === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] response expected none seen one");
            end else begin
                e = exp_q.pop_front();
                chk_flag("abort", e.ab, o_target_abort);
                chk_word("rd_data", e.d & e.m, o_rd_data & e.m);
            end
        end
    end

    // slow area: random latency
    initial begin
        i_ext_ack = 1'b0;
        i_ext_rdata = 32'h0;
        forever begin
            @(negedge i_core_clk);
            if (o_ext_req === 1'b1) begin
                repeat ($random(seed) & 3) @(negedge i_core_clk);
                i_ext_ack = 1'b1;
                i_ext_rdata = {o_ext_addr, ~o_ext_addr};
                @(negedge i_core_clk);
                i_ext_ack = 1'b0;
                i_ext_rdata = $random(seed);
            end
        end
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("[FAIL] watchdog expected done seen timeout");
        print_verdict();
    end

    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_peer_wr = 1'b0;
        i_peer_wdata = 32'h0;
        i_vme_rst_n = 1'b1;
        i_fail_line = 1'b1;
        i_power_fail = 1'b1;
        i_host_rst_n = 1'b1;
        repeat (16) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        chk_word("hwctl", 32'hC, o_hardware_control);
        chk_flag("rst_pin", 1'b1, o_local_reset_pin);
        chk_flag("fail_oe", 1'b1, o_fail_line_oe);
        one(CMD_CFG_RD, 32'h0, BE_DWORD, '0, '0, '1, {DEV, VEN});
        one(CMD_CFG_RD, 32'h8, BE_DWORD, '0, '0, '1, {CLS, REV});
        one(CMD_CFG_WR, 32'h4, BE_DWORD, 32'h2, '0, '0, '0);
        one(CMD_CFG_WR, 32'h10, BE_DWORD, BAR, '0, '0, '0);
        one(CMD_CFG_RD, 32'h10, BE_DWORD, '0, '0, HI, BAR);
        u_host.start(CMD_MEM_RD, 32'h0);
        chk_flag("claim", 1'b0, o_claim);
        u_host.finish();
        done("config");
        one(CMD_MEM_WR, BAR, BE_DWORD, 32'h3, '0, '0, '0);
        chk_flag("rst_pin", 1'b0, o_local_reset_pin);
        chk_flag("fail_oe", 1'b0, o_fail_line_oe);
        one(CMD_MEM_WR, BAR, BE_LO_WORD, 32'h1, '0, '0, '0);
        chk_flag("fail_oe", 1'b1, o_fail_line_oe);
        foreach (rcmd[i]) begin
            one(rcmd[i], BAR, BE_DWORD, '0, '0, '1, 32'hD);
        end
        done("hwctl");
        repeat (6) begin
            fl = 1'($random(seed));
            pf = 1'($random(seed));
            i_fail_line = fl;
            i_power_fail = pf;
            repeat (3) @(negedge i_core_clk);
            chk_word("monitor", {28'h0, pf, fl, 2'h1},
                     o_hardware_control);
        end
        i_fail_line = 1'b1;
        i_power_fail = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_peer_wr = 1'b1;
        i_peer_wdata = 32'h2;
        @(negedge i_core_clk);
        i_peer_wr = 1'b0;
        chk_word("peer", 32'hE, o_hardware_control);
        i_vme_rst_n = 1'b0;
        i_host_rst_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        chk_word("resets", 32'h1C, o_hardware_control);
        i_vme_rst_n = 1'b1;
        i_host_rst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        done("monitors");
        // counter wraps
        u_host.start(CMD_MEM_WR, BAR | 32'h27F8);
        foreach (d[i]) begin
            d[i] = $random(seed);
            op(BE_DWORD, d[i], '0, '0, '0);
        end
        u_host.finish();
        u_host.start(CMD_MEM_RD_MULT, BAR | 32'h27FC);
        op(BE_LO_WORD, '0, '0, LO, d[1]);
        op(BE_HI_WORD, '0, '0, HI, d[1]);
        op(BE_DWORD, '0, '0, '1, d[2]);
        op(BE_DWORD, '0, '0, '1, d[3]);
        u_host.finish();
        done("burst");
        one(CMD_MEM_RD, BAR | 32'h40, BE_DWORD, '0, 1'b1, '0, '0);
        one(CMD_MEM_WR, BAR | 32'h2400, 4'hE, '1, 1'b1, '0, '0);
        one(CMD_MEM_RD, BAR | 32'h800, BE_DWORD, '0, '0, '1,
            32'h0800F7FF);
        u_host.start(CMD_MEM_WR, BAR | 32'h804);
        op(BE_DWORD, d[0], '0, '0, '0);
        op(BE_DWORD, d[1], 1'b1, '0, '0);
        u_host.finish();
        done("aborts");
        print_verdict();
    end
endmodule
`default_nettype wire
